// [sdfm_pkg.sv]
/*
  Package for the switch diagnostic, fault and mode control block: register
  offsets, field positions, reset values, timing figures and the mode states.
  Assumes a 20 MHz APB clock; all times below are converted to cycles here.
*/
package sdfm_pkg;

  // Clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 50000;

  // Times in microseconds, as printed or chosen
  localparam int unsigned WD_TIMEOUT_US = 1000;
  localparam int unsigned STBY_DELAY_US = 1000;
  localparam int unsigned RETRY_US = 1000;

  // Cycle counts derived from the times (every count rounds down)
  localparam int unsigned WD_TIMEOUT_CYC = (WD_TIMEOUT_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned STBY_DELAY_CYC = (STBY_DELAY_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned RETRY_CYC = (RETRY_US * 1000000) / CLK_PERIOD_PS;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] ID_OFS = 8'h08;

  // Control register fields
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_CHECK_BIT = 1;
  localparam int unsigned CTRL_SEL_LO_BIT = 2;
  localparam int unsigned CTRL_SEL_HI_BIT = 3;
  localparam int unsigned CTRL_LATCH_BIT = 4;
  localparam int unsigned CTRL_WDOG_BIT = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  // Sense choice codes
  localparam logic [1:0] SNS_LOAD = 2'h0;
  localparam logic [1:0] SNS_UNUSED = 2'h1;
  localparam logic [1:0] SNS_TEMP = 2'h2;
  localparam logic [1:0] SNS_SUPPLY = 2'h3;

  // Sense output route codes
  localparam logic [2:0] ROUTE_HIZ = 3'h0;
  localparam logic [2:0] ROUTE_LOAD = 3'h1;
  localparam logic [2:0] ROUTE_TEMP = 3'h2;
  localparam logic [2:0] ROUTE_SUPPLY = 3'h3;
  localparam logic [2:0] ROUTE_FAULT = 3'h4;

  // Identity word; value is arbitrary
  localparam logic [31:0] BLOCK_ID = 32'h5d1a_0001;

  // Device modes
  typedef enum logic [2:0] {
    SDFM_STANDBY,
    SDFM_STBY_DELAY,
    SDFM_DIAG,
    SDFM_ACTIVE,
    SDFM_FAULT
  } sdfm_mode_t;

endpackage : sdfm_pkg

// [sdfm_ctrl.sv]
/*
  Control logic of a high-side switch: off-state open-load and battery-short
  detection, sense routing, open-drain status, enable watchdog and the mode
  machine. Assumes the control pins are synchronous to pclk, and that the
  analog stage reports comparator, regulation and shutdown causes as levels.
*/
// Added by the designer: the APB interface to the registers and the register addresses.
// How it works
// - Off-state comparator only when checking and switch off
// - Open-load flag follows comparator continuously
// - Check falling or enable rising clears open-load
// - Sense choice routes load, temperature or supply
// - Fault with choice 00 gives fault current
// - Status open-drain low while fault present
// - Fault is shutdown, regulation or open-load
// - No open-load flag while switch enabled
// - Shutdown always reported; open-load only at 00
// - Enable high too long turns switch off
// - Enable rising edge restarts watchdog
// - Enable falling edge clears fault indications
// - Both low enters delay, then standby
// - Standby offers no diagnostics
// - Diagnostic state checks with switch off
// - Active state switch on, checks optional
// - Shutdown cause in active state enters fault state
// - Leave fault when clear, unlatched, timer done
// - On leaving fault, follow enable
// - Sense fault persists until output risen
module sdfm_ctrl
  import sdfm_pkg::*;
#(
  parameter int unsigned WD_CYC = WD_TIMEOUT_CYC,
  parameter int unsigned STBY_CYC = STBY_DELAY_CYC,
  parameter int unsigned RETRY_CYCLES = RETRY_CYC
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog stage reports
  input wire logic out_above_limit,
  input wire logic out_risen,
  input wire logic current_regulating,
  input wire logic shutdown_cause,
  // Power stage and sense outputs
  output logic switch_on,
  output logic [2:0] sense_route,
  output logic fault_flag_n_o,
  output logic fault_flag_n_oe,
  output logic [2:0] mode
);

  localparam int unsigned CW = 32;

  // Control register and its fields
  logic [5:0] ctrl_q;
  logic enable, check_enable, latch_in, wdog_on;
  logic [1:0] sense_choice_pins;
  assign enable = ctrl_q[CTRL_ENABLE_BIT];
  assign check_enable = ctrl_q[CTRL_CHECK_BIT];
  assign latch_in = ctrl_q[CTRL_LATCH_BIT];
  assign wdog_on = ctrl_q[CTRL_WDOG_BIT];
  assign sense_choice_pins = {ctrl_q[CTRL_SEL_HI_BIT], ctrl_q[CTRL_SEL_LO_BIT]};

  // State registers
  sdfm_mode_t mode_q;
  logic en_q, chk_q;
  logic open_load_q, sns_fault_q, wd_trip_q;
  logic [CW-1:0] wd_cnt_q, stby_cnt_q, retry_cnt_q;
  logic en_rise, en_fall, chk_fall, comp_run, shut_fault, any_fault;

  // APB register access, zero wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= CTRL_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      // A write lands at the access edge, where the master samples pready high
      if (psel && penable && pready && pwrite && paddr == CTRL_OFS)
        ctrl_q <= pwdata[5:0];
      if (psel && !penable)
      begin
        pslverr <= !(paddr == CTRL_OFS || paddr == STAT_OFS || paddr == ID_OFS);
        unique case (paddr)
          CTRL_OFS: prdata <= {26'h0, ctrl_q};
          STAT_OFS: prdata <= {24'h0, sns_fault_q, wd_trip_q, open_load_q, !fault_flag_n_oe, 1'b0, mode_q};
          ID_OFS: prdata <= BLOCK_ID;
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Previous pin levels for edge events
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_q <= 1'b0;
      chk_q <= 1'b0;
    end
    else
    begin
      en_q <= enable;
      chk_q <= check_enable;
    end
  end
  assign en_rise = enable && !en_q;
  assign en_fall = !enable && en_q;
  assign chk_fall = !check_enable && chk_q;

  // Comparator runs only checking with switch off, outside standby
  assign comp_run = check_enable && !enable && mode_q != SDFM_STANDBY;

  // Open-load flag tracks comparator; edges clear it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      open_load_q <= 1'b0;
    else if (chk_fall || en_rise || (wdog_on && en_fall))
      open_load_q <= 1'b0;
    else
      open_load_q <= comp_run && out_above_limit;
  end

  // Watchdog counter restarts on enable rising
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wd_cnt_q <= '0;
      wd_trip_q <= 1'b0;
    end
    else
    begin
      if (en_rise || !enable)
        wd_cnt_q <= '0;
      else if (wd_cnt_q < WD_CYC)
        wd_cnt_q <= wd_cnt_q + 1'b1;
      if (en_fall || !wdog_on)
        wd_trip_q <= 1'b0;
      else if (enable && wd_cnt_q >= WD_CYC - 1)
        wd_trip_q <= 1'b1;
    end
  end

  // Mode machine with standby delay and retry timers
  assign shut_fault = mode_q == SDFM_FAULT;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q <= SDFM_STANDBY;
      stby_cnt_q <= '0;
      retry_cnt_q <= '0;
    end
    else
    begin
      stby_cnt_q <= '0;
      unique case (mode_q)
        SDFM_STANDBY, SDFM_STBY_DELAY, SDFM_DIAG, SDFM_ACTIVE:
        begin
          if (shutdown_cause && mode_q == SDFM_ACTIVE)
          begin
            mode_q <= SDFM_FAULT;
            retry_cnt_q <= '0;
          end
          else if (enable && !(wdog_on && wd_trip_q))
            mode_q <= SDFM_ACTIVE;
          else if (check_enable)
            mode_q <= SDFM_DIAG;
          else if (mode_q == SDFM_STBY_DELAY)
          begin
            stby_cnt_q <= stby_cnt_q + 1'b1;
            if (stby_cnt_q >= STBY_CYC - 1)
              mode_q <= SDFM_STANDBY;
          end
          else if (mode_q != SDFM_STANDBY)
            mode_q <= SDFM_STBY_DELAY;
        end
        SDFM_FAULT:
        begin
          if (retry_cnt_q < RETRY_CYCLES)
            retry_cnt_q <= retry_cnt_q + 1'b1;
          if (!shutdown_cause && !latch_in && retry_cnt_q >= RETRY_CYCLES)
            mode_q <= enable ? SDFM_ACTIVE : (check_enable ? SDFM_DIAG : SDFM_STBY_DELAY);
        end
      endcase
    end
  end

  // Sense fault level holds after retry until the output has risen
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sns_fault_q <= 1'b0;
    else if (shut_fault || current_regulating)
      sns_fault_q <= 1'b1;
    else if (out_risen || mode_q != SDFM_ACTIVE || (wdog_on && en_fall))
      sns_fault_q <= 1'b0;
  end

  // Fault detect is the OR of the three causes
  assign any_fault = shut_fault || current_regulating || open_load_q;

  // Outputs from flip-flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      switch_on <= 1'b0;
      sense_route <= ROUTE_HIZ;
      fault_flag_n_o <= 1'b0;
      fault_flag_n_oe <= 1'b0;
      mode <= 3'h0;
    end
    else
    begin
      switch_on <= mode_q == SDFM_ACTIVE;
      fault_flag_n_o <= 1'b0;
      fault_flag_n_oe <= shut_fault || current_regulating
                         || (open_load_q && sense_choice_pins == SNS_LOAD);
      mode <= mode_q;
      if (!check_enable || mode_q == SDFM_STANDBY)
        sense_route <= ROUTE_HIZ;
      else
        unique case (sense_choice_pins)
          SNS_LOAD: sense_route <= (any_fault || sns_fault_q) ? ROUTE_FAULT : ROUTE_LOAD;
          SNS_TEMP: sense_route <= ROUTE_TEMP;
          SNS_SUPPLY: sense_route <= ROUTE_SUPPLY;
          SNS_UNUSED: sense_route <= ROUTE_HIZ;
        endcase
    end
  end

  // Off-state comparator result appears only when checking with switch off
  a_ol_needs_check: assert property (@(posedge pclk) disable iff (!presetn)
    open_load_q |-> $past(check_enable) && !$past(enable)) else $error("open-load flag outside check");
  a_ol_follows: assert property (@(posedge pclk) disable iff (!presetn)
    (comp_run && out_above_limit && !chk_fall && !en_rise && !(wdog_on && en_fall)) |=> open_load_q)
    else $error("open-load flag missed");
  a_ol_edge_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (chk_fall || en_rise) |=> !open_load_q) else $error("edge did not clear open-load");
  a_ol_not_enabled: assert property (@(posedge pclk) disable iff (!presetn)
    enable |=> !open_load_q)
    else $error("open-load flagged while enabled");

  // Sense routing and status pin
  a_route_hiz: assert property (@(posedge pclk) disable iff (!presetn)
    !check_enable |=> sense_route == ROUTE_HIZ) else $error("sense not high impedance");
  a_route_fault: assert property (@(posedge pclk) disable iff (!presetn)
    (check_enable && sense_choice_pins == SNS_LOAD && any_fault && mode_q != SDFM_STANDBY)
    |=> sense_route == ROUTE_FAULT) else $error("fault current not routed");
  a_flag_drive: assert property (@(posedge pclk) disable iff (!presetn)
    shut_fault |=> fault_flag_n_oe && !fault_flag_n_o) else $error("status not pulled low");
  a_flag_ol_sel: assert property (@(posedge pclk) disable iff (!presetn)
    (!shut_fault && !current_regulating && sense_choice_pins != SNS_LOAD) |=> !fault_flag_n_oe)
    else $error("open-load reported at other choice");
  a_flag_regulate: assert property (@(posedge pclk) disable iff (!presetn)
    current_regulating |=> fault_flag_n_oe)
    else $error("regulation not reported");

  // Watchdog trip, restart and clear
  a_wd_trip: assert property (@(posedge pclk) disable iff (!presetn)
    (wdog_on && wd_trip_q && mode_q != SDFM_FAULT && !shutdown_cause) |=> mode_q != SDFM_ACTIVE)
    else $error("watchdog did not turn off");
  a_wd_restart: assert property (@(posedge pclk) disable iff (!presetn)
    en_rise |=> wd_cnt_q == '0) else $error("watchdog not restarted");
  a_wd_fall_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wdog_on && en_fall) |=> !wd_trip_q && !open_load_q)
    else $error("enable fall kept fault indication");

  // Standby delay and the state outputs
  a_stby_enter: assert property (@(posedge pclk) disable iff (!presetn)
    ((mode_q == SDFM_ACTIVE || mode_q == SDFM_DIAG) && !enable && !check_enable && !shutdown_cause)
    |=> mode_q == SDFM_STBY_DELAY) else $error("standby delay not entered");
  a_stby_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == SDFM_STBY_DELAY && !enable && !check_enable && stby_cnt_q < STBY_CYC - 1)
    |=> mode_q == SDFM_STBY_DELAY) else $error("standby delay cut short");
  a_stby_done: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == SDFM_STBY_DELAY && !enable && !check_enable && stby_cnt_q >= STBY_CYC - 1)
    |=> mode_q == SDFM_STANDBY) else $error("standby not reached");
  a_standby_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == SDFM_STANDBY |=> sense_route == ROUTE_HIZ && !open_load_q)
    else $error("diagnostics active in standby");
  a_diag_off: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == SDFM_DIAG |=> !switch_on)
    else $error("switch on in diagnostic state");
  a_active_on: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == SDFM_ACTIVE |=> switch_on)
    else $error("switch off in active state");

  // Fault entry, latch and retry
  a_fault_enter: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == SDFM_ACTIVE && shutdown_cause) |=> mode_q == SDFM_FAULT) else $error("fault state missed");
  a_fault_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == SDFM_FAULT && latch_in) |=> mode_q == SDFM_FAULT) else $error("left fault while latched");
  a_retry_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == SDFM_FAULT && retry_cnt_q < RETRY_CYCLES) |=> mode_q == SDFM_FAULT)
    else $error("left fault before retry time");

  // Retry steps: leave fault, then the switch follows one cycle later
  sequence s_retry_on;
    mode_q == SDFM_FAULT && !shutdown_cause && !latch_in && retry_cnt_q >= RETRY_CYCLES && enable;
  endsequence
  sequence s_retry_off;
    mode_q == SDFM_FAULT && !shutdown_cause && !latch_in && retry_cnt_q >= RETRY_CYCLES && !enable;
  endsequence
  // Retry into a load whose output cannot rise, or without regulation
  sequence s_retry_dark;
    mode_q == SDFM_FAULT ##1 (mode_q == SDFM_ACTIVE && !out_risen && !(wdog_on && en_fall));
  endsequence
  sequence s_retry_clean;
    mode_q == SDFM_FAULT ##1 (mode_q == SDFM_ACTIVE && !current_regulating);
  endsequence

  a_retry_on: assert property (@(posedge pclk) disable iff (!presetn)
    s_retry_on |=> (mode_q == SDFM_ACTIVE) ##1 switch_on)
    else $error("retry did not re-enable");
  a_retry_off: assert property (@(posedge pclk) disable iff (!presetn)
    s_retry_off |=> (mode_q != SDFM_ACTIVE) ##1 !switch_on)
    else $error("retry enabled without enable");
  a_sns_hold: assert property (@(posedge pclk) disable iff (!presetn)
    s_retry_dark |=> sns_fault_q)
    else $error("sense fault dropped before output rose");
  a_st_retry_clear: assert property (@(posedge pclk) disable iff (!presetn)
    s_retry_clean |=> !fault_flag_n_oe)
    else $error("status fault kept after re-enable");

endmodule : sdfm_ctrl

// [sdfm_analog_model.sv]
/*
  Analog stage model behind the control block: comparator, regulation, shutdown.
  Assumes the bench sets the load conditions as plain levels.
*/
module sdfm_analog_model
(
  // Power stage state
  input wire logic switch_on,
  // Load conditions from the bench
  input wire logic load_open,
  input wire logic overload,
  input wire logic overheat,
  input wire logic gnd_short,
  // Reports to the block
  output logic out_above_limit,
  output logic out_risen,
  output logic current_regulating,
  output logic shutdown_cause
);
  timeunit 1ns;
  timeprecision 1ps;
  // An open load pulls the output up only while the switch is off
  assign out_above_limit = load_open & ~switch_on;
  // A grounded output never rises after a retry
  assign out_risen = switch_on & ~gnd_short;
  assign current_regulating = overload & switch_on;
  assign shutdown_cause = overheat;
endmodule : sdfm_analog_model

// [switch_diag_fault_mode_control_tb_top.sv]
/*
  Self-checking bench for the switch control block over APB.
  Assumes short timer parameters and an analog model on the far side.
*/
module switch_diag_fault_mode_control_tb_top;
  import sdfm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SC = 12; // Standby and retry cycles
  localparam int unsigned WC = 16; // Watchdog cycles
  localparam int unsigned PULSE = 120; // Refresh low time, 6 us at 50 ns
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic out_above_limit, out_risen, current_regulating, shutdown_cause;
  logic load_open, overload, overheat, gnd_short;
  logic switch_on, fault_flag_n_o, fault_flag_n_oe;
  logic [2:0] sense_route, mode;
  int mismatches, checks_done, cycles;

  sdfm_ctrl #(.WD_CYC(WC), .STBY_CYC(SC), .RETRY_CYCLES(SC)) u_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .out_above_limit, .out_risen,
    .current_regulating, .shutdown_cause, .switch_on, .sense_route, .fault_flag_n_o, .fault_flag_n_oe, .mode);
  sdfm_analog_model u_model (.switch_on, .load_open, .overload, .overheat, .gnd_short,
    .out_above_limit, .out_risen, .current_regulating, .shutdown_cause);

  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Hang guard
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      finish_test();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; holds the request until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ends once pready is sampled high; otherwise only the hang guard ends it
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task ctl(input logic [5:0] v);
    apb(1'b1, CTRL_OFS, {26'h0, v});
    repeat (4) @(posedge pclk);
  endtask : ctl

  task expo(input logic [2:0] m, input logic [2:0] r, input logic oe, input logic sw);
    chk({24'h0, mode, sense_route, fault_flag_n_oe, switch_on}, {24'h0, m, r, oe, sw});
  endtask : expo

  task t_regs;
    expo(SDFM_STANDBY, ROUTE_HIZ, 1'b0, 1'b0);
    chk({31'h0, fault_flag_n_o}, 32'h0);
    apb(1'b0, ID_OFS, 32'h0);
    chk(rd, BLOCK_ID);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
  endtask : t_regs

  task t_diag;
    load_open <= 1'b1;
    ctl(6'h02);
    expo(SDFM_DIAG, ROUTE_FAULT, 1'b1, 1'b0);
    ctl(6'h0a);
    expo(SDFM_DIAG, ROUTE_TEMP, 1'b0, 1'b0);
    ctl(6'h0e);
    expo(SDFM_DIAG, ROUTE_SUPPLY, 1'b0, 1'b0);
    ctl(6'h06);
    expo(SDFM_DIAG, ROUTE_HIZ, 1'b0, 1'b0);
    ctl(6'h02);
    load_open <= 1'b0;
    repeat (4) @(posedge pclk);
    expo(SDFM_DIAG, ROUTE_LOAD, 1'b0, 1'b0);
    load_open <= 1'b1;
    ctl(6'h00);
    expo(SDFM_STBY_DELAY, ROUTE_HIZ, 1'b0, 1'b0);
    apb(1'b0, STAT_OFS, 32'h0);
    chk({31'h0, rd[5]}, 32'h0);
    repeat (SC + 4) @(posedge pclk);
    expo(SDFM_STANDBY, ROUTE_HIZ, 1'b0, 1'b0);
  endtask : t_diag

  task t_active;
    ctl(6'h03);
    expo(SDFM_ACTIVE, ROUTE_LOAD, 1'b0, 1'b1);
    overload <= 1'b1;
    repeat (4) @(posedge pclk);
    expo(SDFM_ACTIVE, ROUTE_FAULT, 1'b1, 1'b1);
    ctl(6'h0b);
    expo(SDFM_ACTIVE, ROUTE_TEMP, 1'b1, 1'b1);
    overload <= 1'b0;
    ctl(6'h01);
    expo(SDFM_ACTIVE, ROUTE_HIZ, 1'b0, 1'b1);
  endtask : t_active

  task t_fault;
    ctl(6'h13);
    overheat <= 1'b1;
    repeat (4) @(posedge pclk);
    expo(SDFM_FAULT, ROUTE_FAULT, 1'b1, 1'b0);
    overheat <= 1'b0;
    repeat (SC + 4) @(posedge pclk);
    expo(SDFM_FAULT, ROUTE_FAULT, 1'b1, 1'b0);
    gnd_short <= 1'b1;
    ctl(6'h03);
    repeat (SC) @(posedge pclk);
    expo(SDFM_ACTIVE, ROUTE_FAULT, 1'b0, 1'b1);
    gnd_short <= 1'b0;
    repeat (4) @(posedge pclk);
    expo(SDFM_ACTIVE, ROUTE_LOAD, 1'b0, 1'b1);
  endtask : t_fault

  task t_wdog;
    ctl(6'h20);
    ctl(6'h21);
    chk({31'h0, switch_on}, 32'h1);
    repeat (WC + 4) @(posedge pclk);
    chk({31'h0, switch_on}, 32'h0);
    apb(1'b0, STAT_OFS, 32'h0);
    chk({31'h0, rd[6]}, 32'h1);
    ctl(6'h20);
    apb(1'b0, STAT_OFS, 32'h0);
    chk({31'h0, rd[6]}, 32'h0);
    ctl(6'h21);
    chk({31'h0, switch_on}, 32'h1);
    // Refresh pulse before the watchdog runs out restarts it; the switch is off during the low time and on again after
    repeat (WC - 12) @(posedge pclk);
    apb(1'b1, CTRL_OFS, 32'h0000_0020);
    repeat (PULSE) @(posedge pclk);
    ctl(6'h21);
    repeat (WC - 8) @(posedge pclk);
    chk({31'h0, switch_on}, 32'h1);
  endtask : t_wdog

  task finish_test;
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  // Main sequence
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {load_open, overload, overheat, gnd_short} = 4'h0;
    presetn = 1'b0;
    mismatches = 0;
    checks_done = 0;
    cycles = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_diag();
    t_active();
    t_fault();
    t_wdog();
    finish_test();
  end
endmodule : switch_diag_fault_mode_control_tb_top
